// ===== srap_regs.vh
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH
`define SRAP_ENABLE_PATTERN 5'h1C
`define SRAP_CMD_EN_MSB 15
`define SRAP_CMD_EN_LSB 11
`define SRAP_CMD_DIR_BIT 10
`define SRAP_ADDR_W 10
`define SRAP_DATA_W 16
`define SRAP_ADDR_MAX 10'h3FF
`define SRAP_ADDR_RESET 10'h000
`define SRAP_WORD_LAST 4'hF
`define SRAP_BYTE_BITS 4'h8
`define SRAP_DEV_PREFIX 5'h0B
`define SRAP_SYNC_W 5
`endif

// ===== srap_top.v
`timescale 1ns/10ps
// Functional notes
// - SPI samples input on rising clock, launches output on falling clock.
// - Command top five bits must be 11100 or transaction is ignored.
// - Command bit 10 selects read when 1, write when 0.
// - Command low ten bits give the first register address.
// - SPI write data words after command are stored to addressed register.
// - SPI write pointer increments after every 16-bit word.
// - Writes continue until chip select rises; at maximum address extra data dropped.
// - SPI read drives first data bit on first falling edge after command.
// - Reads continue while clocked; pointer holds at maximum, repeating that register.
// - SPI clock may idle high or low.
// - I2C address is 01011 plus high and low select pins.
// - I2C side is slave only and never starts a transfer.
// - Matching address and each received byte are acknowledged on ninth clock.
// - I2C write sends two pointer bytes; ten low bits form the address.
// - First data byte is upper half, second is lower half.
// - I2C pointer increments per register, no wrap, data dropped at maximum.
// - Stop condition returns to idle and clears pointer to zero.
// - Read follows pointer write; each register returned upper byte first.
// - I2C read auto-increments until not-acknowledge; repeats last register at maximum.
`include "srap_regs.vh"
module srap_top #(
   parameter I2C_VARIANT = 0
) (
   input wire i_clock,
   input wire i_reset,
   input wire i_sclk,
   input wire i_cs_n,
   input wire i_sdi,
   output reg o_sdo,
   output reg o_sdo_oe,
   input wire i_sda,
   output reg o_sda_out,
   output reg o_sda_oe,
   input wire i_addr_select_pin_low,
   input wire i_addr_select_pin_high,
   output reg o_wr_valid,
   input wire i_wr_ready,
   output reg [`SRAP_ADDR_W-1:0] o_wr_addr,
   output reg [`SRAP_DATA_W-1:0] o_wr_data,
   output reg [`SRAP_ADDR_W-1:0] o_rd_addr,
   input wire [`SRAP_DATA_W-1:0] i_rd_data,
   output reg o_word_lost
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_READ = 3'h3;
   localparam [2:0] ST_RX = 3'h4;
   localparam [2:0] ST_ACK = 3'h5;
   localparam [2:0] ST_TX = 3'h6;
   localparam [2:0] ST_MACK = 3'h7;

   // Pin synchronisers: a change counts once stages two and three agree
   wire [`SRAP_SYNC_W-1:0] pin_raw;
   reg [`SRAP_SYNC_W-1:0] s1_reg;
   reg [`SRAP_SYNC_W-1:0] s2_reg;
   reg [`SRAP_SYNC_W-1:0] s3_reg;
   reg [`SRAP_SYNC_W-1:0] filt_reg;
   reg [`SRAP_SYNC_W-1:0] prev_reg;
   assign pin_raw = {i_addr_select_pin_high, i_sda, i_sdi, i_cs_n, i_sclk};
   genvar g;
   generate
      for (g = 0; g < `SRAP_SYNC_W; g = g + 1) begin : g_sync
         always @(posedge i_clock) begin
            if (i_reset) begin
               s1_reg[g] <= 1'b1;
               s2_reg[g] <= 1'b1;
               s3_reg[g] <= 1'b1;
               filt_reg[g] <= 1'b1;
               prev_reg[g] <= 1'b1;
            end else begin
               s1_reg[g] <= pin_raw[g];
               s2_reg[g] <= s1_reg[g];
               s3_reg[g] <= s2_reg[g];
               if (s2_reg[g] == s3_reg[g]) begin
                  filt_reg[g] <= s3_reg[g];
               end
               prev_reg[g] <= filt_reg[g];
            end
         end
      end
   endgenerate
   reg [2:0] sel_s_reg;
   reg sel_low_reg;
   always @(posedge i_clock) begin
      if (i_reset) begin
         sel_s_reg <= 3'h0;
         sel_low_reg <= 1'b0;
      end else begin
         sel_s_reg <= {sel_s_reg[1:0], i_addr_select_pin_low};
         if (sel_s_reg[1] == sel_s_reg[2]) begin
            sel_low_reg <= sel_s_reg[2];
         end
      end
   end

   wire scl = filt_reg[0];
   wire scl_rise = filt_reg[0] & ~prev_reg[0];
   wire scl_fall = ~filt_reg[0] & prev_reg[0];
   wire cs_n = filt_reg[1];
   wire cs_fall = ~filt_reg[1] & prev_reg[1];
   wire sdi = filt_reg[2];
   wire sda = filt_reg[3];
   wire sel_high = filt_reg[4];
   wire i2c_start = scl & prev_reg[0] & prev_reg[3] & ~sda;
   wire i2c_stop = scl & prev_reg[0] & ~prev_reg[3] & sda;

   function [`SRAP_ADDR_W-1:0] srap_next_ptr;
      input [`SRAP_ADDR_W-1:0] p;
      begin
         srap_next_ptr = (p == `SRAP_ADDR_MAX) ? p : p + 10'h001;
      end
   endfunction

   reg [2:0] state_reg;
   reg [3:0] cnt_reg;
   reg [15:0] sh_reg;
   reg [15:0] tx_reg;
   reg [`SRAP_ADDR_W-1:0] ptr_reg;
   reg at_end_reg;
   reg dir_read_reg;
   reg [1:0] byte_idx_reg;
   reg [7:0] hi_byte_reg;
   reg lo_next_reg;
   reg pend_reg;
   reg [`SRAP_ADDR_W-1:0] pend_addr_reg;
   reg [15:0] pend_data_reg;
   reg hold_v_reg;
   reg [`SRAP_ADDR_W-1:0] hold_addr_reg;
   reg [15:0] hold_data_reg;
   reg push_req;
   reg [`SRAP_ADDR_W-1:0] push_addr;
   reg [15:0] push_data;
   wire [15:0] sh_in = {sh_reg[14:0], sdi};
   wire [7:0] rx_byte = {sh_reg[6:0], sda};

   always @* begin
      push_req = 1'b0;
      push_addr = ptr_reg;
      push_data = sh_in;
      if (I2C_VARIANT == 0) begin
         if (state_reg == ST_WRITE && scl_rise && cnt_reg == `SRAP_WORD_LAST && !at_end_reg) begin
            push_req = 1'b1;
         end
      end else if (state_reg == ST_RX && scl_fall && cnt_reg == `SRAP_BYTE_BITS
                   && byte_idx_reg == 2'h3 && !at_end_reg) begin
         push_req = 1'b1;
         push_data = {hi_byte_reg, sh_reg[7:0]};
      end
   end

   always @(posedge i_clock) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 16'h0000;
         tx_reg <= 16'h0000;
         ptr_reg <= `SRAP_ADDR_RESET;
         at_end_reg <= 1'b0;
         dir_read_reg <= 1'b0;
         byte_idx_reg <= 2'h0;
         hi_byte_reg <= 8'h00;
         lo_next_reg <= 1'b0;
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
         o_rd_addr <= `SRAP_ADDR_RESET;
      end else if (I2C_VARIANT == 0) begin
         o_rd_addr <= ptr_reg;
         if (cs_n) begin
            state_reg <= ST_IDLE;
            o_sdo_oe <= 1'b0;
         end else if (cs_fall) begin
            state_reg <= ST_CMD;
            cnt_reg <= 4'h0;
            at_end_reg <= 1'b0;
         end else if (scl_rise && (state_reg == ST_CMD || state_reg == ST_WRITE)) begin
            // Reads count falling edges only; counting rises too would cut each word short
            // Sampling on the rising edge only, so idle level is irrelevant
            sh_reg <= sh_in;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `SRAP_WORD_LAST) begin
               if (state_reg == ST_CMD) begin
                  ptr_reg <= sh_in[`SRAP_ADDR_W-1:0];
                  if (sh_in[`SRAP_CMD_EN_MSB:`SRAP_CMD_EN_LSB] != `SRAP_ENABLE_PATTERN) begin
                     state_reg <= ST_IDLE;
                  end else if (sh_in[`SRAP_CMD_DIR_BIT]) begin
                     state_reg <= ST_READ;
                  end else begin
                     state_reg <= ST_WRITE;
                  end
               end else if (state_reg == ST_WRITE) begin
                  if (ptr_reg == `SRAP_ADDR_MAX) begin
                     at_end_reg <= 1'b1;
                  end
                  ptr_reg <= srap_next_ptr(ptr_reg);
               end
            end
         end else if (scl_fall && state_reg == ST_READ) begin
            // Read data has had a whole half-period to settle before this load
            o_sdo_oe <= 1'b1;
            if (cnt_reg == 4'h0) begin
               o_sdo <= i_rd_data[15];
               tx_reg <= {i_rd_data[14:0], 1'b0};
               ptr_reg <= srap_next_ptr(ptr_reg);
            end else begin
               o_sdo <= tx_reg[15];
               tx_reg <= {tx_reg[14:0], 1'b0};
            end
            cnt_reg <= cnt_reg + 4'h1;
         end
      end else begin
         o_rd_addr <= ptr_reg;
         o_sda_out <= 1'b0;
         if (i2c_stop) begin
            state_reg <= ST_IDLE;
            ptr_reg <= `SRAP_ADDR_RESET;
            at_end_reg <= 1'b0;
            o_sda_oe <= 1'b0;
         end else if (i2c_start) begin
            // Only responds after a master start; it never drives one itself
            state_reg <= ST_CMD;
            cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            o_sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (state_reg == ST_CMD || state_reg == ST_RX) begin
               sh_reg <= {8'h00, rx_byte};
               cnt_reg <= cnt_reg + 4'h1;
            end else if (state_reg == ST_MACK) begin
               lo_next_reg <= lo_next_reg;
               dir_read_reg <= ~sda;
            end
         end else if (scl_fall) begin
            if (state_reg == ST_CMD && cnt_reg == `SRAP_BYTE_BITS) begin
               if (sh_reg[7:1] == {`SRAP_DEV_PREFIX, sel_high, sel_low_reg}) begin
                  o_sda_oe <= 1'b1;
                  state_reg <= ST_ACK;
                  lo_next_reg <= sh_reg[0];
                  dir_read_reg <= 1'b1;
               end else begin
                  state_reg <= ST_IDLE;
               end
            end else if (state_reg == ST_RX && cnt_reg == `SRAP_BYTE_BITS) begin
               o_sda_oe <= 1'b1;
               state_reg <= ST_ACK;
               lo_next_reg <= 1'b0;
               dir_read_reg <= 1'b0;
               case (byte_idx_reg)
                  2'h0: begin
                     hi_byte_reg <= sh_reg[7:0];
                     byte_idx_reg <= 2'h1;
                  end
                  2'h1: begin
                     ptr_reg <= {hi_byte_reg[1:0], sh_reg[7:0]};
                     byte_idx_reg <= 2'h2;
                  end
                  2'h2: begin
                     hi_byte_reg <= sh_reg[7:0];
                     byte_idx_reg <= 2'h3;
                  end
                  default: begin
                     // Pairs must be complete; an odd last byte is never written
                     byte_idx_reg <= 2'h2;
                     if (ptr_reg == `SRAP_ADDR_MAX) begin
                        at_end_reg <= 1'b1;
                     end
                     ptr_reg <= srap_next_ptr(ptr_reg);
                  end
               endcase
            end else if ((state_reg == ST_ACK && lo_next_reg)
                         || (state_reg == ST_MACK && dir_read_reg)
                         || (state_reg == ST_TX && cnt_reg != `SRAP_BYTE_BITS)) begin
               state_reg <= ST_TX;
               if (state_reg != ST_TX) begin
                  // Upper byte first, then lower byte, then advance
                  cnt_reg <= 4'h1;
                  tx_reg <= byte_idx_reg[0] ? {i_rd_data[6:0], 9'h000} : {i_rd_data[14:8], 9'h000};
                  o_sda_oe <= byte_idx_reg[0] ? ~i_rd_data[7] : ~i_rd_data[15];
                  byte_idx_reg <= {1'b0, ~byte_idx_reg[0]};
                  if (byte_idx_reg[0]) begin
                     ptr_reg <= srap_next_ptr(ptr_reg);
                  end
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
                  o_sda_oe <= ~tx_reg[15];
                  tx_reg <= {tx_reg[14:0], 1'b0};
               end
               if (state_reg == ST_ACK) begin
                  byte_idx_reg <= 2'h1;
                  tx_reg <= {i_rd_data[14:8], 9'h000};
                  o_sda_oe <= ~i_rd_data[15];
               end
            end else if (state_reg == ST_TX) begin
               o_sda_oe <= 1'b0;
               state_reg <= ST_MACK;
            end else if (state_reg == ST_ACK) begin
               o_sda_oe <= 1'b0;
               state_reg <= ST_RX;
               cnt_reg <= 4'h0;
            end else if (state_reg == ST_MACK) begin
               // Not-acknowledge: release and wait for the stop
               state_reg <= ST_IDLE;
            end
         end
      end
   end

   // Two-entry write buffer; a pending word waits while both entries are full
   wire buf_full = o_wr_valid & hold_v_reg;
   wire pop = o_wr_valid & i_wr_ready;
   wire take = pend_reg & ~buf_full;
   always @(posedge i_clock) begin
      if (i_reset) begin
         pend_reg <= 1'b0;
         pend_addr_reg <= `SRAP_ADDR_RESET;
         pend_data_reg <= 16'h0000;
         hold_v_reg <= 1'b0;
         hold_addr_reg <= `SRAP_ADDR_RESET;
         hold_data_reg <= 16'h0000;
         o_wr_valid <= 1'b0;
         o_wr_addr <= `SRAP_ADDR_RESET;
         o_wr_data <= 16'h0000;
         o_word_lost <= 1'b0;
      end else begin
         o_word_lost <= push_req & pend_reg & ~take;
         if (push_req) begin
            pend_reg <= 1'b1;
            pend_addr_reg <= push_addr;
            pend_data_reg <= push_data;
         end else if (take) begin
            pend_reg <= 1'b0;
         end
         if (!o_wr_valid || pop) begin
            if (hold_v_reg) begin
               o_wr_valid <= 1'b1;
               o_wr_addr <= hold_addr_reg;
               o_wr_data <= hold_data_reg;
               hold_v_reg <= take;
               hold_addr_reg <= pend_addr_reg;
               hold_data_reg <= pend_data_reg;
            end else begin
               o_wr_valid <= take;
               o_wr_addr <= pend_addr_reg;
               o_wr_data <= pend_data_reg;
            end
         end else if (take) begin
            hold_v_reg <= 1'b1;
            hold_addr_reg <= pend_addr_reg;
            hold_data_reg <= pend_data_reg;
         end
      end
   end
endmodule

// ===== srap_top_assertions.sv
`timescale 1ns/10ps
`include "srap_regs.vh"
module srap_top_assertions #(
   parameter I2C_VARIANT = 0
) (
   input wire i_clock,
   input wire i_reset,
   input wire i_sclk,
   input wire i_cs_n,
   input wire o_sdo,
   input wire o_sdo_oe,
   input wire o_sda_out,
   input wire o_sda_oe,
   input wire o_wr_valid,
   input wire i_wr_ready,
   input wire [`SRAP_ADDR_W-1:0] o_wr_addr,
   input wire [`SRAP_DATA_W-1:0] o_wr_data,
   input wire o_word_lost
);
   logic [5:0] cnt_reg;
   logic seen_reg;
   logic [`SRAP_ADDR_W-1:0] last_reg;
   // Writes may drain after chip select rises, so a frame ends only after a long quiet spell
   always @(posedge i_clock) begin
      if (i_reset) begin
         cnt_reg <= 6'h00;
         seen_reg <= 1'b0;
         last_reg <= `SRAP_ADDR_RESET;
      end else begin
         cnt_reg <= !i_cs_n ? 6'h00 : (cnt_reg == 6'h3F ? cnt_reg : cnt_reg + 6'h01);
         if (o_wr_valid && i_wr_ready) begin
            seen_reg <= 1'b1;
            last_reg <= o_wr_addr;
         end else if (!i_cs_n || cnt_reg == 6'h28) begin
            // A new frame starts its own address run
            seen_reg <= 1'b0;
         end
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   sequence s_taken;
      o_wr_valid && i_wr_ready;
   endsequence
   sequence s_stall;
      o_wr_valid && !i_wr_ready;
   endsequence
   a_sdo_released: assert property (i_cs_n [*8] |-> !o_sdo_oe)
      else $error("SDO driven while chip select high");
   a_oe_in_frame: assert property ($rose(o_sdo_oe) |-> !$past(i_cs_n, 3))
      else $error("SDO enabled outside a frame");
   a_sdo_on_fall: assert property ($changed(o_sdo) && o_sdo_oe && $past(o_sdo_oe)
      |-> !$past(i_sclk, 3) || !$past(i_sclk, 4) || !$past(i_sclk, 5))
      else $error("SDO changed without a falling clock");
   a_wr_holds: assert property (s_stall |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
      else $error("Write request dropped or changed while stalled");
   a_no_loss: assert property (i_wr_ready [*8] |-> !o_word_lost)
      else $error("Word lost with receiver ready");
   a_addr_step: assert property (seen_reg ##0 s_taken |-> o_wr_addr == last_reg + 10'h001)
      else $error("Write address did not step by one");
   a_max_no_wr: assert property (seen_reg && last_reg == `SRAP_ADDR_MAX |-> !o_wr_valid)
      else $error("Write issued past the top address");
   a_sda_quiet: assert property (I2C_VARIANT == 0 |-> !o_sda_oe)
      else $error("Data line pulled in serial variant");
   a_sda_low_only: assert property (o_sda_out == 1'b0)
      else $error("Data line driven high");
endmodule
bind srap_top srap_top_assertions #(.I2C_VARIANT(I2C_VARIANT)) u_srap_chk (.i_clock(i_clock), .i_reset(i_reset),
   .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr),
   .o_wr_data(o_wr_data), .o_word_lost(o_word_lost));

// ===== srap_spi_host.sv
`timescale 1ns/10ps
module srap_spi_host (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_sdo_oe
);
   logic [15:0] wdata [0:3];
   logic [15:0] rdata [0:3];
   logic oe_seen;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b1;
   end
   // Chip select first, command word, then whole words MSB first
   // Clock stands still between frames; data line shows the inverse once released
   task automatic frame(input logic idle, input logic [15:0] cmd, input int nw);
      logic [15:0] w;
      oe_seen = 1'b0;
      o_sclk = idle;
      #80;
      o_cs_n = 1'b0;
      for (int k = 0; k <= nw; k++) begin
         w = (k == 0) ? cmd : wdata[k-1];
         for (int b = 15; b >= 0; b--) begin
            o_sclk = 1'b0;
            o_sdi = w[b];
            #80;
            o_sclk = 1'b1;
            #60;
            if (k > 0) rdata[k-1][b] = i_sdo;
            oe_seen = oe_seen | i_sdo_oe;
            #20;
         end
      end
      o_cs_n = 1'b1;
      o_sdi = ~o_sdi;
      o_sclk = idle;
   endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
`include "srap_regs.vh"
`define CHK(what, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", what, e, g); end end
module tb_top;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic i_wr_ready = 1'b1;
   logic sclk, cs_n, sdi, sdo, sdo_oe, wr_valid, lost_pulse;
   logic [`SRAP_ADDR_W-1:0] wr_addr, rd_addr;
   logic [`SRAP_DATA_W-1:0] wr_data;
   logic [`SRAP_DATA_W-1:0] i_rd_data;
   int mismatches = 0;
   int cmp_count = 0;
   int lost = 0;
   logic [25:0] wq [$];
   assign i_rd_data = {6'h15, rd_addr};
   always #10 i_clock = ~i_clock;
   srap_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
      .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sda(1'b1), .o_sda_out(), .o_sda_oe(),
      .i_addr_select_pin_low(1'b0), .i_addr_select_pin_high(1'b0), .o_wr_valid(wr_valid),
      .i_wr_ready(i_wr_ready), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
      .i_rd_data(i_rd_data), .o_word_lost(lost_pulse));
   srap_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
   always @(posedge i_clock) begin
      if (wr_valid === 1'b1 && i_wr_ready === 1'b1) wq.push_back({wr_addr, wr_data});
      if (lost_pulse === 1'b1) lost++;
   end
   task automatic wait_wq(input int n);
      for (int i = 0; i < 300 && wq.size() < n; i++) @(negedge i_clock);
   endtask
   // Receiver stalls through a three-word write, then drains it
   task automatic t_write_stall;
      host.wdata[0] = 16'h1234;
      host.wdata[1] = 16'hABCD;
      host.wdata[2] = 16'h0F0F;
      i_wr_ready = 1'b0;
      host.frame(1'b0, 16'hE005, 3);
      repeat (50) @(negedge i_clock);
      `CHK("stalled writes", 0, wq.size())
      i_wr_ready = 1'b1;
      wait_wq(3);
      for (int k = 0; k < 3; k++) `CHK("write word", {10'(5 + k), host.wdata[k]}, wq[k])
      `CHK("lost words", 0, lost)
      `CHK("sdo during write", 1'b0, host.oe_seen)
      wq.delete();
      $display("t_write_stall done");
   endtask
   // Idle-high clock, write runs into the top address
   task automatic t_write_max;
      host.wdata[0] = 16'h1111;
      host.wdata[1] = 16'h2222;
      host.wdata[2] = 16'h3333;
      host.frame(1'b1, 16'hE3FE, 3);
      wait_wq(2);
      repeat (100) @(negedge i_clock);
      `CHK("writes at top", 2, wq.size())
      `CHK("write 3FE", {10'h3FE, 16'h1111}, wq[0])
      `CHK("write 3FF", {10'h3FF, 16'h2222}, wq[1])
      wq.delete();
      $display("t_write_max done");
   endtask
   // Bad enable pattern in both directions is ignored
   task automatic t_bad_enable;
      host.frame(1'b0, 16'hF005, 1);
      repeat (100) @(negedge i_clock);
      host.frame(1'b0, 16'hF405, 1);
      repeat (100) @(negedge i_clock);
      `CHK("bad enable writes", 0, wq.size())
      `CHK("bad enable sdo", 1'b0, host.oe_seen)
      $display("t_bad_enable done");
   endtask
   // Read over the top address repeats the last register
   task automatic t_read;
      host.frame(1'b0, 16'hE7FE, 3);
      repeat (100) @(negedge i_clock);
      `CHK("read word 0", {6'h15, 10'h3FE}, host.rdata[0])
      `CHK("read word 1", {6'h15, 10'h3FF}, host.rdata[1])
      `CHK("read word 2", {6'h15, 10'h3FF}, host.rdata[2])
      `CHK("read sdo enable", 1'b1, host.oe_seen)
      `CHK("read writes", 0, wq.size())
      $display("t_read done");
   endtask
   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge i_clock);
      i_reset = 1'b0;
      repeat (5) @(negedge i_clock);
      t_write_stall();
      repeat (100) @(negedge i_clock);
      t_write_max();
      repeat (100) @(negedge i_clock);
      t_bad_enable();
      t_read();
      test_done();
   end
   initial begin
      #400000;
      mismatches++;
      test_done();
   end
endmodule
